//--- rtl/adc_output_format_power_modes.sv
// Purpose: Formats converter samples, drives overrange flag, power modes
// Assumes: Raw sample is signed offset from mid-scale, one per ref_clk
// Notes: Output enables are active low (low while driving)
`include "adc_fmt_defines.svh"

// Notes on behaviour
// - Offset binary: mid code at zero input
// - Saturate out-of-range input, raise flag
// - Flag high means sample out of range
// - Mode ground or third: offset binary
// - Upper modes: invert MSB for twos complement
// - Stabilizer on only at middle levels
// - Enable pin high floats data and flag
// - Shutdown low: normal conversion
// - Shutdown and enable high: sleep
// - Data invalid for milliseconds after sleep
// - Shutdown high, enable low: nap
// - Nap recovery takes 100 clocks
// - Nap and sleep float data and flag outputs
// - Sample on rising edge only
// - Stabilizer lock needs hundred clocks
module adc_output_format_power_modes
  import adc_fmt_pkg::*;
#(
  parameter int unsigned SLEEP_WAKE = `SLEEP_WAKE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Converter core sample, signed offset from mid-scale
  input wire logic signed [`RAW_W-1:0] raw_sample,
  // Strap pins
  input wire logic [1:0] mode_level,
  input wire logic power_down_select,
  input wire logic output_enable_n,
  // Data pins
  output logic [`CODE_W-1:0] sample_code_bits,
  output logic [`CODE_W-1:0] sample_code_bits_oe_n,
  output logic overrange_flag,
  output logic overrange_flag_oe_n,
  // Status
  output logic stabilizer_on,
  output logic data_valid,
  output logic sleeping,
  output logic napping
);
  typedef struct packed {
    logic [1:0] mode_s1, mode_s2;
    logic pd_s1, pd_s2, oe_s1, oe_s2;
    logic [`PIPE_LAT-1:0][`CODE_W-1:0] code_pipe;
    logic [`PIPE_LAT-1:0] of_pipe;
    pwr_e pwr;
    logic [31:0] wake_cnt;
    logic [`CODE_W-1:0] code;
    logic [`CODE_W-1:0] code_oe_n;
    logic ofl;
    logic ofl_oe_n;
    logic stab;
    logic valid;
    logic slp;
    logic nap;
  } state_s;

  state_s st, next_st;
  logic [`CODE_W-1:0] ob_code;
  logic ovr;
  logic twos;
  logic drive;

  always_comb begin
    next_st = st;
    next_st.mode_s1 = mode_level;
    next_st.mode_s2 = st.mode_s1;
    next_st.pd_s1 = power_down_select;
    next_st.pd_s2 = st.pd_s1;
    next_st.oe_s1 = output_enable_n;
    next_st.oe_s2 = st.oe_s1;
    // Saturating offset-binary conversion
    ovr = 1'b0;
    if (raw_sample > $signed(14'sd2047)) begin
      ob_code = `CODE_MAX;
      ovr = 1'b1;
    end else if (raw_sample < $signed(-14'sd2048)) begin
      ob_code = `CODE_MIN;
      ovr = 1'b1;
    end else begin
      ob_code = raw_sample[`CODE_W-1:0] + `CODE_MID;
    end
    twos = st.mode_s2[1];
    // Sampled each rising edge through a fixed pipe
    next_st.code_pipe[0] = twos ? {~ob_code[`CODE_W-1], ob_code[`CODE_W-2:0]} : ob_code;
    next_st.of_pipe[0] = ovr;
    for (int i = 1; i < `PIPE_LAT; i++) begin
      next_st.code_pipe[i] = st.code_pipe[i-1];
      next_st.of_pipe[i] = st.of_pipe[i-1];
    end
    next_st.stab = (st.mode_s2 == `MODE_THIRD) || (st.mode_s2 == `MODE_TWO_THIRD);
    // Power state
    unique case (st.pwr)
      pwr_run: begin
        if (st.pd_s2) begin
          next_st.pwr = st.oe_s2 ? pwr_sleep : pwr_nap;
        end
      end
      pwr_nap: begin
        if (!st.pd_s2) begin
          next_st.pwr = pwr_run;
          next_st.wake_cnt = 32'(`NAP_WAKE_CYC);
        end else if (st.oe_s2) begin
          next_st.pwr = pwr_sleep;
        end
      end
      pwr_sleep: begin
        if (!st.pd_s2) begin
          next_st.pwr = pwr_run;
          next_st.wake_cnt = SLEEP_WAKE;
        end else if (!st.oe_s2) begin
          next_st.pwr = pwr_nap;
        end
      end
      default: next_st.pwr = pwr_sleep;
    endcase
    if (st.pwr == pwr_run && st.wake_cnt != 32'h0) begin
      next_st.wake_cnt = st.wake_cnt - 32'h1;
    end
    // Stabilizer newly on: give the loop time to lock
    if (next_st.stab && !st.stab && st.wake_cnt < 32'(`STAB_LOCK_CYC)) begin
      next_st.wake_cnt = 32'(`STAB_LOCK_CYC);
    end
    drive = (st.pwr == pwr_run) && !st.oe_s2;
    next_st.code = st.code_pipe[`PIPE_LAT-1];
    next_st.ofl = st.of_pipe[`PIPE_LAT-1];
    next_st.code_oe_n = {`CODE_W{~drive}};
    next_st.ofl_oe_n = ~drive;
    next_st.valid = (st.pwr == pwr_run) && (st.wake_cnt == 32'h0);
    next_st.slp = (st.pwr == pwr_sleep);
    next_st.nap = (st.pwr == pwr_nap);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.pwr <= pwr_run;
      st.code_oe_n <= {`CODE_W{1'b1}};
      st.ofl_oe_n <= 1'b1;
      st.oe_s1 <= 1'b1;
      st.oe_s2 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sample_code_bits = st.code;
  assign sample_code_bits_oe_n = st.code_oe_n;
  assign overrange_flag = st.ofl;
  assign overrange_flag_oe_n = st.ofl_oe_n;
  assign stabilizer_on = st.stab;
  assign data_valid = st.valid;
  assign sleeping = st.slp;
  assign napping = st.nap;

  // Release edge excluded: the pipe still holds reset zeros then
  property p_sat_flag;
    @(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) && (raw_sample > $signed(14'sd2047))
        |-> ##(`PIPE_LAT + 1) (overrange_flag && (sample_code_bits[10:0] == 11'h7ff));
  endproperty
  a_sat_flag: assert property (p_sat_flag) else $error("overrange not flagged");

  property p_inrange;
    @(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) && (raw_sample == 14'sd0) && !st.mode_s2[1] && $stable(st.mode_s2)
        |-> ##(`PIPE_LAT + 1) (sample_code_bits == `CODE_MID);
  endproperty
  a_inrange: assert property (p_inrange) else $error("zero input not mid code");

  property p_stab;
    @(posedge ref_clk) disable iff (sys_rst)
      ##1 stabilizer_on == ($past(st.mode_s2) == `MODE_THIRD || $past(st.mode_s2) == `MODE_TWO_THIRD);
  endproperty
  a_stab: assert property (p_stab) else $error("stabilizer level wrong");

  property p_float;
    @(posedge ref_clk) disable iff (sys_rst)
      (st.oe_s2 || st.pwr != pwr_run) |=> (overrange_flag_oe_n && (&sample_code_bits_oe_n));
  endproperty
  a_float: assert property (p_float) else $error("outputs driven while disabled");

  property p_sleep;
    @(posedge ref_clk) disable iff (sys_rst)
      (st.pwr == pwr_run && st.pd_s2 && st.oe_s2) |=> ##1 sleeping;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_nap;
    @(posedge ref_clk) disable iff (sys_rst)
      (st.pwr == pwr_run && st.pd_s2 && !st.oe_s2) |=> ##1 napping;
  endproperty
  a_nap: assert property (p_nap) else $error("nap not entered");

  property p_nap_wake;
    @(posedge ref_clk) disable iff (sys_rst)
      (st.pwr == pwr_nap && !st.pd_s2) |=> !data_valid [*8];
  endproperty
  a_nap_wake: assert property (p_nap_wake) else $error("valid too soon after nap");

  property p_run_drive;
    @(posedge ref_clk) disable iff (sys_rst)
      (st.pwr == pwr_run && !st.oe_s2) |=> !overrange_flag_oe_n;
  endproperty
  a_run_drive: assert property (p_run_drive) else $error("normal mode not driving");

  property p_twos;
    @(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) && (raw_sample == 14'sd0) && st.mode_s2[1] && $stable(st.mode_s2)
        |-> ##(`PIPE_LAT + 1) (sample_code_bits == 12'h000);
  endproperty
  a_twos: assert property (p_twos) else $error("twos complement zero wrong");
endmodule // adc_output_format_power_modes

//--- inc/adc_fmt_defines.svh
// Purpose: Constants for the converter output formatter
// Assumes: 12-bit codes, 50 MHz ref_clk standing in for the sampling clock
// Notes: Definitions only
`ifndef ADC_FMT_DEFINES_SVH
`define ADC_FMT_DEFINES_SVH
`define CODE_W 12
`define CODE_MID 12'h800
`define CODE_MAX 12'hfff
`define CODE_MIN 12'h000
`define RAW_W 14
`define RAW_FULL 14'h0fff
`define PIPE_LAT 3
`define NAP_WAKE_CYC 100
`define STAB_LOCK_CYC 100
`define SLEEP_WAKE_MS 2
`define CLK_MHZ 50
`define SLEEP_WAKE_CYC (`SLEEP_WAKE_MS * 1000 * `CLK_MHZ)
`define MODE_GND 2'h0
`define MODE_THIRD 2'h1
`define MODE_TWO_THIRD 2'h2
`define MODE_VDD 2'h3
`endif

//--- inc/adc_fmt_pkg.sv
// Purpose: Types for the converter output formatter
// Assumes: Nothing beyond the defines header
// Notes: Power states one-hot
package adc_fmt_pkg;
  typedef enum logic [2:0] {
    pwr_run = 3'b001,
    pwr_nap = 3'b010,
    pwr_sleep = 3'b100
  } pwr_e;
endpackage

//--- verification/capture_latch_model.sv
// Purpose: Capture latch on the far side of the sample bus
// Assumes: Samples taken on the rising sampling clock edge
// Notes: Floated pads show the inverse of their last level
module capture_latch_model (
  // Clock
  input wire logic ref_clk,
  // Pads from the converter
  input wire logic [11:0] sample_code_bits,
  input wire logic [11:0] sample_code_bits_oe_n,
  input wire logic overrange_flag,
  input wire logic overrange_flag_oe_n,
  input wire logic data_valid,
  // Captured word
  output logic [11:0] held_code,
  output logic held_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] last_code = 12'h000;
  logic last_flag = 1'b0;
  logic [11:0] pad_code;
  logic pad_flag;
  // No keeper on the bus, so a floated pad is not its old value
  assign pad_code = (sample_code_bits & ~sample_code_bits_oe_n) | (~last_code & sample_code_bits_oe_n);
  assign pad_flag = overrange_flag_oe_n ? ~last_flag : overrange_flag;
  initial held_code = 12'h000;
  initial held_flag = 1'b0;
  always @(posedge ref_clk) begin
    // Remember only what was really driven
    last_code <= (sample_code_bits & ~sample_code_bits_oe_n) | (last_code & sample_code_bits_oe_n);
    last_flag <= overrange_flag_oe_n ? last_flag : overrange_flag;
    // Recovery time discarded; code and flag taken on one edge
    if (data_valid === 1'b1) begin
      held_code <= pad_code;
      held_flag <= pad_flag;
    end
  end
endmodule // capture_latch_model

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the output formatter
// Assumes: Sleep wake shortened to 20 cycles
// Notes: Straps change well apart except enable and shutdown, flipped on one edge twice; enable only while idle
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic signed [13:0] raw_sample = 14'h0000;
  logic [1:0] mode_level = 2'h0;
  logic power_down_select = 1'b0;
  logic output_enable_n = 1'b0;
  logic [11:0] sample_code_bits, sample_code_bits_oe_n, held_code;
  logic overrange_flag, overrange_flag_oe_n, stabilizer_on, data_valid, sleeping, napping, held_flag;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic signed [13:0] vals[7] = '{14'h0000, 14'h0001, 14'h3fff, 14'h07ff, 14'h3800, 14'h0800, 14'h37ff};
  logic [11:0] obs[7] = '{12'h800, 12'h801, 12'h7ff, 12'hfff, 12'h000, 12'hfff, 12'h000};
  logic ofl[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  always #10 ref_clk = ~ref_clk;
  adc_output_format_power_modes #(.SLEEP_WAKE(20)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .raw_sample(raw_sample), .mode_level(mode_level), .power_down_select(power_down_select),
    .output_enable_n(output_enable_n), .sample_code_bits(sample_code_bits),
    .sample_code_bits_oe_n(sample_code_bits_oe_n), .overrange_flag(overrange_flag),
    .overrange_flag_oe_n(overrange_flag_oe_n), .stabilizer_on(stabilizer_on), .data_valid(data_valid),
    .sleeping(sleeping), .napping(napping));
  capture_latch_model partner (.ref_clk(ref_clk), .sample_code_bits(sample_code_bits),
    .sample_code_bits_oe_n(sample_code_bits_oe_n), .overrange_flag(overrange_flag),
    .overrange_flag_oe_n(overrange_flag_oe_n), .data_valid(data_valid), .held_code(held_code),
    .held_flag(held_flag));
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_valid(input int lim);
    for (int i = 0; i < lim && data_valid !== 1'b1; i++) @(posedge ref_clk);
    #1;
    `CHK("valid_up", 1'b1, data_valid)
  endtask
  task automatic run_code(input logic signed [13:0] v, input logic [11:0] ob, input logic fl);
    logic [11:0] ex;
    ex = ob ^ ((mode_level >= 2'h2) ? 12'h800 : 12'h000);
    @(posedge ref_clk) raw_sample <= v;
    wait_cyc(8);
    `CHK("code", ex, held_code)
    `CHK("flag", fl, held_flag)
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    wait_cyc(4);
    @(posedge ref_clk) sys_rst <= 1'b0;
    wait_cyc(4);
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk) mode_level <= m[1:0];
      wait_cyc(60);
      `CHK("stab", (m == 1 || m == 2), stabilizer_on)
      if (m == 1) `CHK("lock", 1'b0, data_valid)
      wait_valid(200);
      for (int k = 0; k < 7; k++) run_code(vals[k], obs[k], ofl[k]);
    end
    @(posedge ref_clk) raw_sample <= 14'h0001;
    wait_cyc(3);
    `CHK("lat_old", 12'h800, sample_code_bits)
    wait_cyc(1);
    `CHK("lat_new", 12'h001, sample_code_bits)
    `CHK("drive", 12'h000, sample_code_bits_oe_n)
    // Enable changed only with sampling idle
    @(posedge ref_clk) output_enable_n <= 1'b1;
    wait_cyc(6);
    `CHK("oe_code", 12'hfff, sample_code_bits_oe_n)
    `CHK("oe_flag", 1'b1, overrange_flag_oe_n)
    `CHK("no_sleep", 1'b0, sleeping)
    @(posedge ref_clk) power_down_select <= 1'b1;
    wait_cyc(6);
    `CHK("sleep", 1'b1, sleeping)
    `CHK("sl_float", 12'hfff, sample_code_bits_oe_n)
    @(posedge ref_clk) output_enable_n <= 1'b0;
    wait_cyc(6);
    `CHK("nap", 1'b1, napping)
    `CHK("nap_code", 12'hfff, sample_code_bits_oe_n)
    `CHK("nap_flag", 1'b1, overrange_flag_oe_n)
    @(posedge ref_clk) power_down_select <= 1'b0;
    wait_cyc(90);
    `CHK("nap_wake", 1'b0, data_valid)
    wait_valid(30);
    @(posedge ref_clk) output_enable_n <= 1'b1;
    power_down_select <= 1'b1;
    wait_cyc(6);
    @(posedge ref_clk) power_down_select <= 1'b0;
    output_enable_n <= 1'b0;
    wait_cyc(8);
    `CHK("sl_wake", 1'b0, data_valid)
    wait_valid(60);
    // Straight from normal running into nap
    @(posedge ref_clk) power_down_select <= 1'b1;
    wait_cyc(6);
    `CHK("run_nap", 1'b1, napping)
    `CHK("run_nap_flag", 1'b1, overrange_flag_oe_n)
    @(posedge ref_clk) power_down_select <= 1'b0;
    wait_cyc(8);
    `CHK("nap_hold", 1'b0, data_valid)
    wait_valid(120);
    close_out();
  end
endmodule // tb_top
